// [tb/frame_ctrl_model.sv]
`timescale 1ns/10ps
module frame_ctrl_model (
  input wire logic core_clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // --------------------------------
  // one menu choice relayed as one transfer
  // --------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // waits for the answer; only the bench watchdog ends a dead wait
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not look like held data
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : frame_ctrl_model

// [tb/tb.sv]
`timescale 1ns/10ps
module tb import video_cfg_pkg::*; ;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic ctrl_present, video_valid, video_hd, cpu_active, primary_reclocked;
  logic [7:0] major_alarm, minor_alarm;
  logic [4:0] src_route, star_slot;
  logic [2:0] sync_route, enc_composite;
  downconvert_aspect_mode_t aspect_mode;
  hires_out_mode_t hires_mode;
  logic led_major, led_minor, led_cpu, led_video_valid, led_video_hd;
  int mismatches = 0;
  int checked = 0;
  int seed = 93206;
  int toggles;
  logic led_prev;

  always #5 core_clk = ~core_clk;

  frame_ctrl_model u_ctrl (.core_clk(core_clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  video_routing_status_ctrl #(.FLASH_CYCLES(4)) u_dut (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl_present(ctrl_present),
    .video_valid(video_valid), .video_hd(video_hd), .cpu_active(cpu_active),
    .major_alarm(major_alarm), .minor_alarm(minor_alarm), .src_route(src_route),
    .star_slot(star_slot), .sync_route(sync_route), .aspect_mode(aspect_mode),
    .primary_reclocked(primary_reclocked), .hires_mode(hires_mode),
    .enc_composite(enc_composite), .led_major(led_major), .led_minor(led_minor),
    .led_cpu(led_cpu), .led_video_valid(led_video_valid), .led_video_hd(led_video_hd));

  // --------------------------------
  // expectations and helpers
  // --------------------------------
  function automatic logic [4:0] slot_of(int s);
    return (s == 3) ? 5'h05 : (s == 4) ? 5'h10 : 5'h00;
  endfunction : slot_of

  function automatic logic [31:0] hires_of(logic [3:0] c, logic hd);
    return !c[0] ? 32'h0 : hd ? 32'h1 : 32'h2;
  endfunction : hires_of

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
    u_ctrl.xfer(1'b1, a, d, rd, err);
    chk("pslverr", {31'h0, exp_err}, {31'h0, err});
    repeat (2) @(negedge core_clk);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp,
                       input logic exp_err);
    u_ctrl.xfer(1'b0, a, 32'h0, rd, err);
    chk("pslverr", {31'h0, exp_err}, {31'h0, err});
    if (!exp_err) begin
      chk(nm, exp, rd);
    end
  endtask : rdchk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    {ctrl_present, video_valid, video_hd, cpu_active} = 4'h0;
    major_alarm = 8'h00;
    minor_alarm = 8'h00;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk("src_route", 5'h01, src_route);
    chk("sync_route", 3'h1, sync_route);
    chk("primary", 1'b1, primary_reclocked);
    repeat (6) @(posedge core_clk);
    wr(SOURCE_SEL_OFS, 32'h2, 1'b1);
    chk("src_route", 5'h01, src_route);
    @(posedge core_clk);
    ctrl_present <= 1'b1;
    repeat (6) @(posedge core_clk);
    for (int s = 0; s < 5; s++) begin
      wr(SOURCE_SEL_OFS, s, 1'b0);
      chk("src_route", 5'h01 << s, src_route);
      chk("star_slot", slot_of(s), star_slot);
      rdchk("source", SOURCE_SEL_OFS, s, 1'b0);
    end
    wr(SOURCE_SEL_OFS, 32'h5, 1'b1);
    chk("src_route", 5'h10, src_route);
    for (int s = 0; s < 3; s++) begin
      wr(SYNC_REF_OFS, s, 1'b0);
      chk("sync_route", 3'h1 << s, sync_route);
      rdchk("sync", SYNC_REF_OFS, s, 1'b0);
      wr(ASPECT_OFS, s, 1'b0);
      chk("aspect", s, aspect_mode);
      rdchk("aspect_rd", ASPECT_OFS, s, 1'b0);
    end
    wr(SYNC_REF_OFS, 32'h3, 1'b1);
    wr(ASPECT_OFS, 32'h3, 1'b1);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      @(posedge core_clk);
      {video_valid, video_hd} <= v[9:8];
      major_alarm <= (i == 0) ? 8'h00 : v[23:16];
      minor_alarm <= (i == 1) ? 8'h00 : v[31:24];
      repeat (8) @(negedge core_clk);
      wr(OUTPUT_CFG_OFS, {28'h0, v[3:0]}, 1'b0);
      chk("hires", hires_of(v[3:0], video_hd), hires_mode);
      chk("enc", v[3:1], enc_composite);
      chk("primary", 1'b1, primary_reclocked);
      chk("led_major", |major_alarm, led_major);
      chk("led_minor", |minor_alarm, led_minor);
      chk("led_valid", video_valid, led_video_valid);
      chk("led_hd", video_hd, led_video_hd);
      rdchk("summary", MAJOR_SUMMARY_OFS, {23'h0, ~|major_alarm, major_alarm}, 1'b0);
      rdchk("outcfg", OUTPUT_CFG_OFS, {28'h0, v[3:0]}, 1'b0);
      v = {27'h0, 1'b1, |minor_alarm, |major_alarm, video_hd, video_valid};
      rdchk("status", STATUS_OFS, v, 1'b0);
    end
    wr(STATUS_OFS, 32'h1f, 1'b1);
    wr(MAJOR_SUMMARY_OFS, 32'h1ff, 1'b1);
    rdchk("unmapped", 8'h18, 32'h0, 1'b1);
    @(posedge core_clk);
    cpu_active <= 1'b1;
    toggles = 0;
    led_prev = led_cpu;
    repeat (40) begin
      @(negedge core_clk);
      if (led_cpu !== led_prev) begin
        toggles++;
      end
      led_prev = led_cpu;
    end
    // 4 edges through the synchroniser, then one toggle per 4-cycle half period
    chk("cpu_flash", 32'd8, toggles);
    @(posedge core_clk);
    cpu_active <= 1'b0;
    repeat (20) @(negedge core_clk);
    chk("cpu_idle", 1'b0, led_cpu);
    @(posedge core_clk);
    ctrl_present <= 1'b0;
    repeat (8) @(negedge core_clk);
    chk("src_route", 5'h01, src_route);
    chk("enc", 3'h0, enc_composite);
    @(posedge core_clk);
    ctrl_present <= 1'b1;
    repeat (8) @(posedge core_clk);
    wr(SOURCE_SEL_OFS, 32'h2, 1'b0);
    chk("src_route", 5'h04, src_route);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk("src_route", 5'h01, src_route);
    report_and_stop();
  end
endmodule : tb

// [verilog/activity_flasher.sv]
`timescale 1ns/10ps
module activity_flasher import video_cfg_pkg::*; #(
  parameter int HALF_CYCLES = FLASH_HALF_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic active,
  output logic led
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic led_reg;
  logic led_next;

  // dark when idle, so a stuck processor never looks alive
  always_comb begin
    cnt_next = cnt_reg;
    led_next = led_reg;
    if (!active) begin
      cnt_next = '0;
      led_next = 1'b0;
    end else if (cnt_reg == 32'(HALF_CYCLES - 1)) begin
      cnt_next = '0;
      led_next = !led_reg;
    end else begin
      cnt_next = cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      led_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      led_reg <= led_next;
    end
  end

  assign led = led_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_FLASH_IDLE_DARK: assert property (!active |=> !led)
    else $error("status light lit while processor idle");
  AST_FLASH_TOGGLE: assert property (
    active && cnt_reg == 32'(HALF_CYCLES - 1) |=> led != $past(led))
    else $error("status light failed to toggle");

endmodule : activity_flasher

// [verilog/pin_sync3.sv]
`timescale 1ns/10ps
module pin_sync3 import video_cfg_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  // a bit only moves once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule : pin_sync3

// [verilog/video_cfg_pkg.sv]
package video_cfg_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] SOURCE_SEL_OFS = 8'h00;
  localparam logic [7:0] SYNC_REF_OFS = 8'h04;
  localparam logic [7:0] ASPECT_OFS = 8'h08;
  localparam logic [7:0] OUTPUT_CFG_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] MAJOR_SUMMARY_OFS = 8'h14;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int OUT_HDSD_BIT = 0;
  localparam int OUT_ENC_LSB = 1;
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_HD_BIT = 1;
  localparam int STAT_MAJOR_BIT = 2;
  localparam int STAT_MINOR_BIT = 3;
  localparam int STAT_CTRL_BIT = 4;
  localparam int SUMMARY_OK_BIT = 8;
  localparam int ALARM_W = 8;
  localparam int ENC_OUTS = 3;

  // ----------------------------------------
  // selection codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    SRC_REAR_COAX = 3'h0,
    SRC_LEFT = 3'h1,
    SRC_RIGHT = 3'h2,
    SRC_STAR_A = 3'h3,
    SRC_STAR_B = 3'h4
  } input_source_t;

  typedef enum logic [1:0] {
    sync_from_input_video = 2'h0,
    external_reference_a = 2'h1,
    external_reference_b = 2'h2
  } sync_reference_select_t;

  typedef enum logic [1:0] {
    aspect_center_extract = 2'h0,
    aspect_bars_top_bottom = 2'h1,
    aspect_horizontal_squeeze = 2'h2
  } downconvert_aspect_mode_t;

  typedef enum logic [1:0] {
    HIRES_RECLOCKED = 2'h0,
    HIRES_DOWNCONVERTED = 2'h1,
    HIRES_SYNC_SD = 2'h2
  } hires_out_mode_t;

  localparam logic [4:0] STAR_A_SLOT = 5'h05;
  localparam logic [4:0] STAR_B_SLOT = 5'h10;

  // ----------------------------------------
  // carriers and reset values
  // ----------------------------------------
  typedef struct packed {
    input_source_t src;
    sync_reference_select_t sync_ref;
    downconvert_aspect_mode_t aspect;
    logic hires_down;
    logic [ENC_OUTS-1:0] enc_composite;
  } cfg_t;

  typedef struct packed {
    logic ctrl_present;
    logic video_valid;
    logic video_hd;
    logic cpu_active;
    logic [ALARM_W-1:0] major;
    logic [ALARM_W-1:0] minor;
  } pin_status_t;

  localparam int PIN_W = $bits(pin_status_t);

  localparam cfg_t FACTORY_CFG_RESET = '{
    src: SRC_REAR_COAX,
    sync_ref: sync_from_input_video,
    aspect: aspect_center_extract,
    hires_down: 1'b0,
    enc_composite: 3'h0
  };

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_MHZ * 1000;

endpackage : video_cfg_pkg

// [verilog/video_routing_status_ctrl.sv]
// Operation
// - five input sources selectable; active choice readable back
// - star A routes the slot 5 card, star B the slot 16 card
// - sync reference: input video, external A or B; active choice reported
// - aspect modes: centre extract, bars top and bottom, horizontal squeeze
// - primary outputs always re-clocked input with audio, never configurable
// - hires output: re-clocked or down-converted; with down-conversion set, SD input gives synchronized SD
// - two SD/encoder outputs and option output: SD digital or composite
// - without controller, factory configuration applies and cannot be changed
// - red light on any major alarm, yellow on any minor alarm
// - processor status light flashes while processor active
// - first logic light lit only while valid video present
// - second logic light lit for HD input, dark for SD input
// - major summary shows raising alarms, or OK when none active
// - major summary is read only; writes refused
// - exactly one input source routed at any time
// - factory source default is the rear panel connector
`timescale 1ns/10ps
module video_routing_status_ctrl import video_cfg_pkg::*; #(
  parameter cfg_t FACTORY_CFG = FACTORY_CFG_RESET,
  parameter int FLASH_CYCLES = FLASH_HALF_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ctrl_present,
  input wire logic video_valid,
  input wire logic video_hd,
  input wire logic cpu_active,
  input wire logic [ALARM_W-1:0] major_alarm,
  input wire logic [ALARM_W-1:0] minor_alarm,
  output logic [4:0] src_route,
  output logic [4:0] star_slot,
  output logic [2:0] sync_route,
  output downconvert_aspect_mode_t aspect_mode,
  output logic primary_reclocked,
  output hires_out_mode_t hires_mode,
  output logic [ENC_OUTS-1:0] enc_composite,
  output logic led_major,
  output logic led_minor,
  output logic led_cpu,
  output logic led_video_valid,
  output logic led_video_hd
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  pin_status_t pins_raw;
  pin_status_t pins;
  logic [PIN_W-1:0] pins_flat;

  assign pins_raw = '{ctrl_present, video_valid, video_hd, cpu_active, major_alarm,
                      minor_alarm};

  pin_sync3 #(.WIDTH(PIN_W)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(pins_raw),
    .sync_out(pins_flat)
  );

  assign pins = pin_status_t'(pins_flat);

  function automatic logic [4:0] src_onehot(input input_source_t s);
    src_onehot = 5'h01 << s;
  endfunction : src_onehot

  function automatic logic is_cfg_ofs(input logic [7:0] a);
    is_cfg_ofs = (a == SOURCE_SEL_OFS) || (a == SYNC_REF_OFS) || (a == ASPECT_OFS) ||
                 (a == OUTPUT_CFG_OFS);
  endfunction : is_cfg_ofs

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RESP = 3'b010,
    ST_DONE = 3'b100
  } apb_state_t;

  apb_state_t st_reg;
  apb_state_t st_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  cfg_t cfg_reg;
  cfg_t cfg_next;
  logic commit;
  logic bad_req;
  logic [31:0] rd_val;

  // answer is given one cycle into the access phase
  assign commit = (st_reg == ST_RESP) && psel && penable && !pslverr_reg;

  always_comb begin
    rd_val = 32'h0;
    bad_req = 1'b0;
    if (paddr == SOURCE_SEL_OFS) begin
      rd_val = {29'h0, cfg_reg.src};
      bad_req = pwrite && (pwdata[2:0] > SRC_STAR_B);
    end else if (paddr == SYNC_REF_OFS) begin
      rd_val = {30'h0, cfg_reg.sync_ref};
      bad_req = pwrite && (pwdata[1:0] > external_reference_b);
    end else if (paddr == ASPECT_OFS) begin
      rd_val = {30'h0, cfg_reg.aspect};
      bad_req = pwrite && (pwdata[1:0] > aspect_horizontal_squeeze);
    end else if (paddr == OUTPUT_CFG_OFS) begin
      rd_val = {28'h0, cfg_reg.enc_composite, cfg_reg.hires_down};
    end else if (paddr == STATUS_OFS) begin
      rd_val = {27'h0, pins.ctrl_present, |pins.minor, |pins.major, pins.video_hd,
                pins.video_valid};
      bad_req = pwrite;
    end else if (paddr == MAJOR_SUMMARY_OFS) begin
      rd_val = {23'h0, ~|pins.major, pins.major};
      bad_req = pwrite;
    end else begin
      bad_req = 1'b1;
    end
    if (is_cfg_ofs(paddr) && pwrite && !pins.ctrl_present) begin
      bad_req = 1'b1;
    end
  end

  always_comb begin
    st_next = st_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    case (st_reg)
      ST_IDLE: begin
        if (psel && penable) begin
          st_next = ST_RESP;
          pready_next = 1'b1;
          pslverr_next = bad_req;
          prdata_next = pwrite ? 32'h0 : rd_val;
        end
      end
      ST_RESP: begin
        st_next = ST_DONE;
      end
      ST_DONE: begin
        st_next = ST_IDLE;
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // configuration
  // ----------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    if (!pins.ctrl_present) begin
      cfg_next = FACTORY_CFG;
    end else if (commit && pwrite) begin
      if (paddr == SOURCE_SEL_OFS) begin
        cfg_next.src = input_source_t'(pwdata[2:0]);
      end else if (paddr == SYNC_REF_OFS) begin
        cfg_next.sync_ref = sync_reference_select_t'(pwdata[1:0]);
      end else if (paddr == ASPECT_OFS) begin
        cfg_next.aspect = downconvert_aspect_mode_t'(pwdata[1:0]);
      end else if (paddr == OUTPUT_CFG_OFS) begin
        cfg_next.hires_down = pwdata[OUT_HDSD_BIT];
        cfg_next.enc_composite = pwdata[OUT_ENC_LSB +: ENC_OUTS];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= ST_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
      cfg_reg <= FACTORY_CFG;
    end else begin
      st_reg <= st_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      cfg_reg <= cfg_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------
  // routing and indicator outputs
  // ----------------------------------------
  logic [4:0] src_route_reg;
  logic [4:0] star_slot_reg;
  logic [4:0] star_slot_next;
  logic [2:0] sync_route_reg;
  downconvert_aspect_mode_t aspect_reg;
  logic primary_reg;
  hires_out_mode_t hires_reg;
  hires_out_mode_t hires_next;
  logic [ENC_OUTS-1:0] enc_reg;
  logic [4:1] led_reg;

  always_comb begin
    // star buses map to fixed slots
    star_slot_next = 5'h00;
    if (cfg_reg.src == SRC_STAR_A) begin
      star_slot_next = STAR_A_SLOT;
    end else if (cfg_reg.src == SRC_STAR_B) begin
      star_slot_next = STAR_B_SLOT;
    end
    hires_next = HIRES_RECLOCKED;
    if (cfg_reg.hires_down) begin
      hires_next = pins.video_hd ? HIRES_DOWNCONVERTED : HIRES_SYNC_SD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_route_reg <= 5'h01;
      star_slot_reg <= 5'h00;
      sync_route_reg <= 3'h1;
      aspect_reg <= aspect_center_extract;
      primary_reg <= 1'b1;
      hires_reg <= HIRES_RECLOCKED;
      enc_reg <= '0;
      led_reg <= '0;
    end else begin
      src_route_reg <= src_onehot(cfg_reg.src);
      star_slot_reg <= star_slot_next;
      sync_route_reg <= 3'h1 << cfg_reg.sync_ref;
      aspect_reg <= cfg_reg.aspect;
      primary_reg <= 1'b1;
      hires_reg <= hires_next;
      enc_reg <= cfg_reg.enc_composite;
      led_reg <= {|pins.major, |pins.minor, pins.video_valid, pins.video_hd};
    end
  end

  activity_flasher #(.HALF_CYCLES(FLASH_CYCLES)) u_flash (
    .core_clk(core_clk),
    .rst(rst),
    .active(pins.cpu_active),
    .led(led_cpu)
  );

  assign src_route = src_route_reg;
  assign star_slot = star_slot_reg;
  assign sync_route = sync_route_reg;
  assign aspect_mode = aspect_reg;
  assign primary_reclocked = primary_reg;
  assign hires_mode = hires_reg;
  assign enc_composite = enc_reg;
  assign led_major = led_reg[4];
  assign led_minor = led_reg[3];
  assign led_video_valid = led_reg[2];
  assign led_video_hd = led_reg[1];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_SRC_ONEHOT: assert property ($onehot(src_route))
    else $error("input route not exactly one source");
  AST_SRC_FOLLOWS: assert property (
    commit && pwrite && paddr == SOURCE_SEL_OFS && pins.ctrl_present
    |=> cfg_reg.src == $past(pwdata[2:0]) ##1 src_route == src_onehot(cfg_reg.src))
    else $error("source write did not route");
  AST_STAR_SLOT: assert property (
    cfg_reg.src == SRC_STAR_B |=> star_slot == STAR_B_SLOT)
    else $error("star B not routed from its slot");
  AST_SYNC_ONEHOT: assert property (
    $onehot(sync_route) && sync_route != 3'h0)
    else $error("sync reference route invalid");
  AST_ASPECT_LEGAL: assert property (aspect_mode != 2'h3)
    else $error("illegal aspect mode");
  AST_PRIMARY_FIXED: assert property (primary_reclocked)
    else $error("primary outputs altered");
  AST_HIRES_SD: assert property (
    cfg_reg.hires_down && !pins.video_hd |=> hires_mode == HIRES_SYNC_SD)
    else $error("SD input not synchronized on hires output");
  AST_ENC_CFG: assert property (
    enc_composite == $past(cfg_reg.enc_composite))
    else $error("encoder outputs not following setting");
  AST_NO_CTRL_FACTORY: assert property (
    !pins.ctrl_present |=> cfg_reg == FACTORY_CFG)
    else $error("settings changed without controller");
  AST_ALARM_LEDS: assert property (
    ##1 led_major == $past(|pins.major) && led_minor == $past(|pins.minor))
    else $error("alarm lights wrong");
  AST_VALID_LED: assert property (
    pins.video_valid ##1 pins.video_valid |=> led_video_valid)
    else $error("valid video light dark");
  AST_HD_LED: assert property (!pins.video_hd |=> !led_video_hd)
    else $error("hd light lit for SD input");
  AST_SUMMARY_RO: assert property (
    st_reg == ST_IDLE && psel && penable && pwrite && paddr == MAJOR_SUMMARY_OFS
    |=> pready && pslverr ##1 cfg_reg == $past(cfg_reg))
    else $error("summary write accepted");
  AST_RESET_FACTORY: assert property ($fell(rst) |-> cfg_reg == FACTORY_CFG)
    else $error("reset did not load factory settings");

  COV_STAR_A: cover property (src_route == 5'h08);
  COV_SYNC_SD: cover property (hires_mode == HIRES_SYNC_SD);
  COV_LOCKED: cover property (pready && pslverr && !pins.ctrl_present);
  COV_MAJOR: cover property (led_major);

endmodule : video_routing_status_ctrl
